/* File: verilog/apv_pkg.sv */
/*
  package for the axis parameter validation and pulse output block.
  assumes one clock and a plain register port.
*/
package apv_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL      = 5'h00;
  localparam logic [4:0] OFS_STATUS    = 5'h01;
  localparam logic [4:0] OFS_PPR       = 5'h02;
  localparam logic [4:0] OFS_UUPR      = 5'h03;
  localparam logic [4:0] OFS_VLIM      = 5'h04;
  localparam logic [4:0] OFS_MANINIT   = 5'h05;
  localparam logic [4:0] OFS_MANMAX    = 5'h06;
  localparam logic [4:0] OFS_AUTOINIT  = 5'h07;
  localparam logic [4:0] OFS_HOMEFIND  = 5'h08;
  localparam logic [4:0] OFS_HOMEFINAL = 5'h09;
  localparam logic [4:0] OFS_UPLIM     = 5'h0a;
  localparam logic [4:0] OFS_LOLIM     = 5'h0b;
  localparam logic [4:0] OFS_INCH      = 5'h0c;
  localparam logic [4:0] OFS_BACKLASH  = 5'h0d;
  localparam logic [4:0] OFS_HOMEOFS   = 5'h0e;
  localparam logic [4:0] OFS_REGDIST   = 5'h0f;
  localparam logic [4:0] OFS_HOMEPOS   = 5'h10;
  localparam logic [4:0] OFS_MOVE      = 5'h11;
  localparam int         NUM_PARAM     = 17;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int CTRL_FLOAT_BIT  = 0;
  localparam int CTRL_UNITS_BIT  = 1;
  localparam int CTRL_INPUT_BIT  = 2;
  localparam int CTRL_TWOPLS_BIT = 3;
  localparam int CTRL_DIRLOW_BIT = 4;
  localparam int CTRL_CLRERR_BIT = 5;
  localparam int STAT_ERR_BIT    = 0;
  localparam int STAT_PEND_BIT   = 1;
  localparam int STAT_BUSY_BIT   = 2;
  localparam int MOVE_REV_BIT    = 31;

  // ----------------------------------------------------------------
  // limits and reset values
  // ----------------------------------------------------------------
  localparam logic signed [63:0] INT_POS_MAX   = 64'sh0000_0000_7fff_ffff;
  localparam logic signed [63:0] INT_NEG_MIN   = -64'sh0000_0000_8000_0000;
  localparam logic signed [63:0] FLT_POS_MAX   = 64'sh0000_0000_7fff_ffbf;
  localparam logic signed [63:0] FLT_NEG_MIN   = -64'sh0000_0000_7fff_ffbf;
  localparam logic        [63:0] MAX_PPS       = 64'h0000_0000_001e_8480;
  localparam logic [31:0] RST_PPR      = 32'h0000_07d0;
  localparam logic [31:0] RST_UUPR     = 32'h0000_07d0;
  localparam logic [31:0] RST_VLIM     = 32'h0000_c350;
  localparam logic [31:0] RST_UPLIM    = 32'h3fff_ffff;
  localparam logic [31:0] RST_LOLIM    = 32'hc000_0000;
  localparam logic [31:0] RST_VEL      = 32'h0000_0064;

  // ----------------------------------------------------------------
  // pulse timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ       = 100;
  localparam int PULSE_NS      = 1000;
  localparam int PULSE_CYC     = (PULSE_NS * CLK_MHZ + 999) / 1000;

  typedef struct packed {
    logic [4:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } apv_bus_type;

  typedef struct packed {
    logic step;
    logic dir;
    logic cw;
    logic ccw;
  } apv_pins_type;

endpackage

/* File: verilog/apv_pulse_gen.sv */
/*
  pulse output stage: step/direction or two-pulse drive, and
  feedback pulse counting in input mode.
  assumes raw pins already synchronised by the caller.
*/
`timescale 1ns/1ps
module apv_pulse_gen (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire logic                  inputMode,
  input  wire logic                  twoPulse,
  input  wire logic                  dirLowFwd,
  input  wire logic                  start,
  input  wire logic                  reverse,
  input  wire logic [31:0]           count,
  input  wire logic                  fbPulse,
  input  wire logic                  fbRev,
  output apv_pkg::apv_pins_type      pins,
  output logic                       busy,
  output logic signed [31:0]         fbPos
);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {IDLE, HIGH, LOW} apv_pst_type;
  apv_pst_type  state_r;
  logic [31:0]  remain_r;
  logic [15:0]  tick_r;
  logic         rev_r;
  logic         fbPrev_r;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_r  <= IDLE;
      remain_r <= 32'h0;
      tick_r   <= 16'h0;
      rev_r    <= 1'b0;
    end
    else
    begin
      case (state_r)
        IDLE:
        begin
          if (start && !inputMode && count != 32'h0)
          begin
            remain_r <= count;
            rev_r    <= reverse;
            tick_r   <= 16'(apv_pkg::PULSE_CYC - 1);
            state_r  <= HIGH;
          end
        end
        HIGH:
        begin
          if (tick_r == 16'h0)
          begin
            tick_r  <= 16'(apv_pkg::PULSE_CYC - 1);
            state_r <= LOW;
          end
          else
            tick_r <= tick_r - 16'h1;
        end
        LOW:
        begin
          if (tick_r != 16'h0)
            tick_r <= tick_r - 16'h1;
          else if (remain_r == 32'h1)
          begin
            remain_r <= 32'h0;
            state_r  <= IDLE;
          end
          else
          begin
            remain_r <= remain_r - 32'h1;
            tick_r   <= 16'(apv_pkg::PULSE_CYC - 1);
            state_r  <= HIGH;
          end
        end
        default:
          state_r <= IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pins, registered
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      pins <= '0;
    else
    begin
      pins.step <= (state_r == HIGH) && !twoPulse;
      pins.dir  <= rev_r ^ !dirLowFwd;
      pins.cw   <= (state_r == HIGH) && twoPulse && rev_r;
      pins.ccw  <= (state_r == HIGH) && twoPulse && !rev_r;
    end
  end

  assign busy = (state_r != IDLE);

  // ----------------------------------------------------------------
  // feedback counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      fbPos    <= 32'sh0;
      fbPrev_r <= 1'b0;
    end
    else
    begin
      fbPrev_r <= fbPulse;
      if (inputMode && fbPulse && !fbPrev_r)
        fbPos <= fbRev ? fbPos - 32'sh1 : fbPos + 32'sh1;
    end
  end

endmodule

/* File: verilog/apv_axis.sv */
/*
  one axis: parameter store with derived-limit and ordering checks,
  holding of dependent changes, error flag and motion gating.
  assumes a single-cycle register master on clk_sys.
*/
`timescale 1ns/1ps
module apv_axis (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  apv_pkg::apv_bus_type       bus,
  output logic [31:0]                rdata,
  input  wire logic                  fbPulsePin,
  input  wire logic                  fbRevPin,
  output apv_pkg::apv_pins_type      pins
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [31:0] act_r  [apv_pkg::NUM_PARAM];
  logic [31:0] cand   [apv_pkg::NUM_PARAM];
  logic [31:0] ctrl_r;
  logic        err_r;
  logic        pend_r;
  logic [4:0]  pendIdx_r;
  logic [31:0] pendVal_r;
  logic        busy;
  logic        moveGo;
  logic signed [31:0] fbPos;
  logic [2:0]  fbSyn_r;
  logic [2:0]  revSyn_r;
  logic        fbClean_r;
  logic        revClean_r;
  logic        candOk;
  logic        hardOk;
  logic        isParam;

  function automatic logic signed [63:0] sx(input logic [31:0] v);
    sx = {{32{v[31]}}, v};
  endfunction

  function automatic logic signed [63:0] mag(input logic [31:0] v);
    mag = v[31] ? -sx(v) : sx(v);
  endfunction

  assign isParam = (bus.addr >= apv_pkg::OFS_PPR) && (bus.addr <= apv_pkg::OFS_HOMEPOS);

  // candidate set: active values with the held and new writes laid over
  always_comb
  begin
    for (int i = 0; i < apv_pkg::NUM_PARAM; i++)
      cand[i] = act_r[i];
    if (pend_r)
      cand[pendIdx_r] = pendVal_r;
    if (bus.wr && isParam)
      cand[bus.addr] = bus.wdata;
  end

  // ----------------------------------------------------------------
  // validation
  // ----------------------------------------------------------------
  logic signed [63:0] ppr, uupr, vlim, upl, lol, homeSum;
  logic signed [63:0] posMax, negMin;

  always_comb
  begin
    ppr     = sx(cand[apv_pkg::OFS_PPR]);
    uupr    = sx(cand[apv_pkg::OFS_UUPR]);
    vlim    = sx(cand[apv_pkg::OFS_VLIM]);
    upl     = sx(cand[apv_pkg::OFS_UPLIM]);
    lol     = sx(cand[apv_pkg::OFS_LOLIM]);
    homeSum = sx(cand[apv_pkg::OFS_HOMEPOS]) + sx(cand[apv_pkg::OFS_HOMEOFS]);
    posMax  = ctrl_r[apv_pkg::CTRL_FLOAT_BIT] ? apv_pkg::FLT_POS_MAX
                                             : apv_pkg::INT_POS_MAX;
    negMin  = ctrl_r[apv_pkg::CTRL_FLOAT_BIT] ? apv_pkg::FLT_NEG_MIN
                                             : apv_pkg::INT_NEG_MIN;
    hardOk  = (upl <= posMax) && (lol >= negMin);
    if (ctrl_r[apv_pkg::CTRL_UNITS_BIT] && ppr > 0 && uupr > 0)
    begin
      // limits scaled by pulses per unit, cross-multiplied to avoid division
      hardOk = hardOk
        && (vlim * ppr <= $signed(apv_pkg::MAX_PPS) * uupr)
        && (upl * ppr <= apv_pkg::INT_POS_MAX * uupr)
        && (lol * ppr >= apv_pkg::INT_NEG_MIN * uupr);
    end
    candOk = hardOk
      && (sx(cand[apv_pkg::OFS_MANINIT]) <= vlim)
      && (sx(cand[apv_pkg::OFS_MANMAX]) <= vlim)
      && (sx(cand[apv_pkg::OFS_AUTOINIT]) <= vlim)
      && (sx(cand[apv_pkg::OFS_MANINIT]) <= sx(cand[apv_pkg::OFS_MANMAX]))
      && (sx(cand[apv_pkg::OFS_HOMEFINAL]) <= sx(cand[apv_pkg::OFS_HOMEFIND]))
      && (mag(cand[apv_pkg::OFS_INCH]) <= upl)
      && (mag(cand[apv_pkg::OFS_BACKLASH]) <= upl)
      && (mag(cand[apv_pkg::OFS_HOMEOFS]) <= upl)
      && (mag(cand[apv_pkg::OFS_REGDIST]) <= upl)
      && (homeSum <= upl)
      && (homeSum >= lol);
  end

  // ----------------------------------------------------------------
  // parameter update
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      for (int i = 0; i < apv_pkg::NUM_PARAM; i++)
        act_r[i] <= 32'h0;
      act_r[apv_pkg::OFS_PPR]       <= apv_pkg::RST_PPR;
      act_r[apv_pkg::OFS_UUPR]      <= apv_pkg::RST_UUPR;
      act_r[apv_pkg::OFS_VLIM]      <= apv_pkg::RST_VLIM;
      act_r[apv_pkg::OFS_UPLIM]     <= apv_pkg::RST_UPLIM;
      act_r[apv_pkg::OFS_LOLIM]     <= apv_pkg::RST_LOLIM;
      act_r[apv_pkg::OFS_MANINIT]   <= apv_pkg::RST_VEL;
      act_r[apv_pkg::OFS_MANMAX]    <= apv_pkg::RST_VEL;
      act_r[apv_pkg::OFS_AUTOINIT]  <= apv_pkg::RST_VEL;
      act_r[apv_pkg::OFS_HOMEFIND]  <= apv_pkg::RST_VEL;
      act_r[apv_pkg::OFS_HOMEFINAL] <= apv_pkg::RST_VEL;
      pend_r    <= 1'b0;
      pendIdx_r <= 5'h0;
      pendVal_r <= 32'h0;
    end
    else if (bus.wr && isParam)
    begin
      if (candOk)
      begin
        for (int i = 0; i < apv_pkg::NUM_PARAM; i++)
          act_r[i] <= cand[i];
        pend_r <= 1'b0;
      end
      else if (hardOk)
      begin
        pend_r    <= 1'b1;
        pendIdx_r <= bus.addr;
        pendVal_r <= bus.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // control and error
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      ctrl_r <= 32'h0;
    else if (bus.wr && bus.addr == apv_pkg::OFS_CTRL)
      ctrl_r <= {26'h0, 1'b0, bus.wdata[4:0]};
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      err_r <= 1'b0;
    else if (bus.wr && isParam && !candOk)
      err_r <= 1'b1;
    else if (bus.wr && bus.addr == apv_pkg::OFS_CTRL
             && bus.wdata[apv_pkg::CTRL_CLRERR_BIT])
      err_r <= 1'b0;
  end

  assign moveGo = bus.wr && bus.addr == apv_pkg::OFS_MOVE && !err_r && !pend_r
                  && !busy;

  // ----------------------------------------------------------------
  // feedback pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      fbSyn_r    <= 3'h0;
      revSyn_r   <= 3'h0;
      fbClean_r  <= 1'b0;
      revClean_r <= 1'b0;
    end
    else
    begin
      fbSyn_r  <= {fbSyn_r[1:0], fbPulsePin};
      revSyn_r <= {revSyn_r[1:0], fbRevPin};
      if (fbSyn_r[2] == fbSyn_r[1])
        fbClean_r <= fbSyn_r[2];
      if (revSyn_r[2] == revSyn_r[1])
        revClean_r <= revSyn_r[2];
    end
  end

  apv_pulse_gen u_pulse (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .inputMode (ctrl_r[apv_pkg::CTRL_INPUT_BIT]),
    .twoPulse  (ctrl_r[apv_pkg::CTRL_TWOPLS_BIT]),
    .dirLowFwd (ctrl_r[apv_pkg::CTRL_DIRLOW_BIT]),
    .start     (moveGo),
    .reverse   (bus.wdata[apv_pkg::MOVE_REV_BIT]),
    .count     ({1'b0, bus.wdata[30:0]}),
    .fbPulse   (fbClean_r),
    .fbRev     (revClean_r),
    .pins      (pins),
    .busy      (busy),
    .fbPos     (fbPos)
  );

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rdata <= 32'h0;
    else if (bus.rd)
    begin
      if (bus.addr == apv_pkg::OFS_CTRL)
        rdata <= ctrl_r;
      else if (bus.addr == apv_pkg::OFS_STATUS)
        rdata <= {29'h0, busy, pend_r, err_r};
      else if (isParam)
        rdata <= act_r[bus.addr];
      else if (bus.addr == apv_pkg::OFS_MOVE)
        rdata <= fbPos;
      else
        rdata <= 32'h0;
    end
    else
      rdata <= 32'h0;
  end

endmodule

/* File: sim/apv_axis_sva.sv */
/*
  port checker for apv_axis.
  bound from the bench top; sees only the top ports.
*/
`timescale 1ns/1ps
module apv_axis_sva (
  input wire logic             clk_sys,
  input wire logic             rst,
  input apv_pkg::apv_bus_type  bus,
  input wire logic [31:0]      rdata,
  input wire logic             fbPulsePin,
  input wire logic             fbRevPin,
  input apv_pkg::apv_pins_type pins
);
  logic [7:0] hiCnt_r;
  logic [7:0] loCnt_r;
  logic       twoPls_r;
  logic       dirLow_r;
  logic       moveRev_r;

  // ----------------------------------------------------------------
  // pulse run lengths, low run saturates
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      hiCnt_r <= 8'h00;
      loCnt_r <= 8'hff;
    end
    else
    begin
      hiCnt_r <= pins.step ? hiCnt_r + 8'h01 : 8'h00;
      loCnt_r <= pins.step ? 8'h00 : (loCnt_r == 8'hff ? loCnt_r : loCnt_r + 8'h01);
    end
  end

  // mode and direction as last written
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      twoPls_r  <= 1'b0;
      dirLow_r  <= 1'b0;
      moveRev_r <= 1'b0;
    end
    else if (bus.wr && bus.addr == apv_pkg::OFS_CTRL)
    begin
      twoPls_r <= bus.wdata[apv_pkg::CTRL_TWOPLS_BIT];
      dirLow_r <= bus.wdata[apv_pkg::CTRL_DIRLOW_BIT];
    end
    else if (bus.wr && bus.addr == apv_pkg::OFS_MOVE)
      moveRev_r <= bus.wdata[apv_pkg::MOVE_REV_BIT];
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 32'h0)
    else $error("read data not zero outside answer cycle");
  a_reset_quiet: assert property ($fell(rst) |-> pins == '0 && rdata == 32'h0)
    else $error("outputs not quiet after reset");
  a_step_width: assert property ($fell(pins.step) |-> hiCnt_r == 8'(apv_pkg::PULSE_CYC))
    else $error("step high time wrong");
  a_step_gap: assert property ($rose(pins.step) |-> loCnt_r >= 8'(apv_pkg::PULSE_CYC))
    else $error("step low time too short");
  a_pulse_excl: assert property (!(pins.cw && pins.ccw))
    else $error("both pulse lines active");
  a_step_mode: assert property (twoPls_r |-> !pins.step)
    else $error("step active in two-pulse mode");
  a_pair_mode: assert property (!twoPls_r |-> !pins.cw && !pins.ccw)
    else $error("pulse pair active in step mode");
  a_cw_reverse: assert property ($rose(pins.cw) |-> moveRev_r)
    else $error("cw pulse on forward move");
  a_ccw_forward: assert property ($rose(pins.ccw) |-> !moveRev_r)
    else $error("ccw pulse on reverse move");
  a_dir_level: assert property (pins.step |-> pins.dir == (moveRev_r ^ !dirLow_r))
    else $error("direction level wrong during step");
endmodule

/* File: sim/apv_drive_model.sv */
/*
  drive and encoder stand-in: counts pulses, makes feedback pulses.
  assumes pins come straight from apv_axis.
*/
`timescale 1ns/1ps
module apv_drive_model (
  input wire logic             clk_sys,
  input apv_pkg::apv_pins_type pins,
  output logic                 fbPulsePin,
  output logic                 fbRevPin
);
  int                    stepHi = 0;
  int                    stepLo = 0;
  int                    cwCnt = 0;
  int                    ccwCnt = 0;
  apv_pkg::apv_pins_type prev = '0;

  initial
  begin
    fbPulsePin = 1'b0;
    fbRevPin = 1'b0;
  end

  // step counted by direction level at its rise
  always @(posedge clk_sys)
  begin
    prev <= pins;
    if (pins.step && !prev.step && pins.dir) stepHi <= stepHi + 1;
    if (pins.step && !prev.step && !pins.dir) stepLo <= stepLo + 1;
    if (pins.cw && !prev.cw) cwCnt <= cwCnt + 1;
    if (pins.ccw && !prev.ccw) ccwCnt <= ccwCnt + 1;
  end

  task automatic emit(input int n, input logic rev);
    fbRevPin <= rev;
    repeat (n)
    begin
      repeat (4) @(posedge clk_sys);
      fbPulsePin <= 1'b1;
      repeat (4) @(posedge clk_sys);
      fbPulsePin <= 1'b0;
    end
  endtask
endmodule

/* File: sim/apv_axis_test.sv */
/*
  self-checking bench for apv_axis with the drive model.
  assumes a 100 MHz clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
module apv_axis_test;
  logic                  clk_sys = 1'b0;
  logic                  rst = 1'b1;
  apv_pkg::apv_bus_type  bus = '0;
  logic [31:0]           rdata;
  logic                  fbPulsePin;
  logic                  fbRevPin;
  apv_pkg::apv_pins_type pins;
  int                    errCount = 0;
  int                    samplesChecked = 0;
  int                    seed = 81;
  logic [31:0]           ctrl = 32'h0;
  logic [31:0]           rnd;
  logic                  rev;
  int                    i, n, m, f, r, b0, b1, b2, b3;

  always #5 clk_sys = ~clk_sys;

  apv_axis u_apv_axis (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata),
    .fbPulsePin(fbPulsePin), .fbRevPin(fbRevPin), .pins(pins));
  apv_drive_model u_apv_drive_model (.clk_sys(clk_sys), .pins(pins),
    .fbPulsePin(fbPulsePin), .fbRevPin(fbRevPin));

  task automatic finish_test;
    if (errCount == 0 && samplesChecked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      errCount++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask

  task automatic rdv(input logic [4:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic rdChk(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] v;
    rdv(a, v);
    check(v, e);
  endtask

  // write, check status, clear the error when one is expected
  task automatic wrChk(input logic [4:0] a, input logic [31:0] d, input logic [31:0] e);
    wr(a, d);
    rdChk(apv_pkg::OFS_STATUS, e);
    if (e[0])
    begin
      wr(apv_pkg::OFS_CTRL, ctrl | 32'h20);
      rdChk(apv_pkg::OFS_STATUS, e & 32'h2);
    end
  endtask

  task automatic waitIdle;
    logic [31:0] s;
    for (int k = 0; k < 1000; k++)
    begin
      rdv(apv_pkg::OFS_STATUS, s);
      if (s[apv_pkg::STAT_BUSY_BIT] === 1'b0)
        return;
    end
    errCount++;
    finish_test();
  endtask

  function automatic logic expDir(input logic rv, input logic dirLow);
    return rv ^ !dirLow;
  endfunction

  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    rdChk(apv_pkg::OFS_STATUS, 32'h0);
    rdChk(apv_pkg::OFS_PPR, apv_pkg::RST_PPR);
    rdChk(apv_pkg::OFS_UPLIM, apv_pkg::RST_UPLIM);
    rdChk(5'h15, 32'h0);
    ctrl = 32'h1;
    wr(apv_pkg::OFS_CTRL, ctrl);
    wrChk(apv_pkg::OFS_UPLIM, 32'h7fff_ffc0, 32'h1);
    rdChk(apv_pkg::OFS_UPLIM, apv_pkg::RST_UPLIM);
    wrChk(apv_pkg::OFS_UPLIM, 32'h7fff_ffbf, 32'h0);
    wrChk(apv_pkg::OFS_LOLIM, 32'h8000_0040, 32'h1);
    wrChk(apv_pkg::OFS_LOLIM, 32'h8000_0041, 32'h0);
    ctrl = 32'h0;
    wr(apv_pkg::OFS_CTRL, ctrl);
    wrChk(apv_pkg::OFS_UPLIM, 32'h7fff_ffff, 32'h0);
    wrChk(apv_pkg::OFS_LOLIM, 32'h8000_0000, 32'h0);
    wrChk(apv_pkg::OFS_UPLIM, apv_pkg::RST_UPLIM, 32'h0);
    wrChk(apv_pkg::OFS_LOLIM, apv_pkg::RST_LOLIM, 32'h0);
    // 4000 pulses per 2000 units
    wrChk(apv_pkg::OFS_PPR, 32'h0000_0fa0, 32'h0);
    ctrl = 32'h2;
    wr(apv_pkg::OFS_CTRL, ctrl);
    wrChk(apv_pkg::OFS_VLIM, 32'h000f_4241, 32'h1);
    wrChk(apv_pkg::OFS_VLIM, 32'h000f_4240, 32'h0);
    wrChk(apv_pkg::OFS_UPLIM, 32'h4000_0000, 32'h1);
    wrChk(apv_pkg::OFS_LOLIM, 32'hbfff_ffff, 32'h1);
    rdChk(apv_pkg::OFS_LOLIM, apv_pkg::RST_LOLIM);
    wrChk(apv_pkg::OFS_HOMEFIND, 32'h000f_4241, 32'h0);
    ctrl = 32'h0;
    wr(apv_pkg::OFS_CTRL, ctrl);
    wrChk(apv_pkg::OFS_MANMAX, 32'h32, 32'h3);
    wrChk(apv_pkg::OFS_MANINIT, 32'h28, 32'h0);
    rdChk(apv_pkg::OFS_MANMAX, 32'h32);
    wr(apv_pkg::OFS_MANMAX, 32'ha);
    b0 = u_apv_drive_model.stepHi + u_apv_drive_model.stepLo;
    wr(apv_pkg::OFS_MOVE, 32'h2);
    repeat (300) @(posedge clk_sys);
    check(u_apv_drive_model.stepHi + u_apv_drive_model.stepLo - b0, 32'h0);
    rdChk(apv_pkg::OFS_STATUS, 32'h3);
    wrChk(apv_pkg::OFS_MANINIT, 32'h5, 32'h1);
    // host lowers dependants first, then the bound
    wrChk(apv_pkg::OFS_AUTOINIT, 32'h32, 32'h0);
    wrChk(apv_pkg::OFS_VLIM, 32'h40, 32'h0);
    wrChk(apv_pkg::OFS_HOMEFINAL, 32'h40, 32'h0);
    wrChk(apv_pkg::OFS_HOMEFIND, 32'h50, 32'h0);
    wrChk(apv_pkg::OFS_INCH, 32'h100, 32'h0);
    wrChk(apv_pkg::OFS_INCH, 32'h8, 32'h0);
    wrChk(apv_pkg::OFS_HOMEOFS, 32'h8, 32'h0);
    wrChk(apv_pkg::OFS_HOMEPOS, 32'h8, 32'h0);
    wrChk(apv_pkg::OFS_UPLIM, 32'h40, 32'h0);
    wrChk(apv_pkg::OFS_HOMEPOS, 32'h28, 32'h0);
    wrChk(apv_pkg::OFS_LOLIM, 32'h20, 32'h0);
    // upper below home sum is held until the sum follows
    wrChk(apv_pkg::OFS_UPLIM, 32'h20, 32'h3);
    wrChk(apv_pkg::OFS_HOMEPOS, 32'h18, 32'h0);
    rdChk(apv_pkg::OFS_UPLIM, 32'h20);
    for (i = 0; i < 8; i++)
    begin
      rnd = $random(seed);
      rev = (i < 6) ? (i >= 3) : rnd[0];
      n = int'(rnd[9:8]) % 3 + 1;
      m = (i < 6) ? i % 3 : int'(rnd[5:4]) % 3;
      ctrl = (m == 1) ? 32'h10 : ((m == 2) ? 32'h8 : 32'h0);
      wr(apv_pkg::OFS_CTRL, ctrl);
      b0 = u_apv_drive_model.stepHi;
      b1 = u_apv_drive_model.stepLo;
      b2 = u_apv_drive_model.cwCnt;
      b3 = u_apv_drive_model.ccwCnt;
      wr(apv_pkg::OFS_MOVE, {rev, 31'(n)});
      waitIdle();
      if (m == 2)
      begin
        check(u_apv_drive_model.cwCnt - b2, rev ? n : 0);
        check(u_apv_drive_model.ccwCnt - b3, rev ? 0 : n);
      end
      else
      begin
        check(u_apv_drive_model.stepHi - b0, expDir(rev, m == 1) ? n : 0);
        check(u_apv_drive_model.stepLo - b1, expDir(rev, m == 1) ? 0 : n);
      end
    end
    ctrl = 32'h4;
    wr(apv_pkg::OFS_CTRL, ctrl);
    wrChk(apv_pkg::OFS_REGDIST, 32'h20, 32'h0);
    rnd = $random(seed);
    f = int'(rnd[2:0]) + 1;
    r = int'(rnd[5:4]) + 1;
    u_apv_drive_model.emit(f, 1'b0);
    u_apv_drive_model.emit(r, 1'b1);
    repeat (8) @(posedge clk_sys);
    rdChk(apv_pkg::OFS_MOVE, 32'(f - r));
    finish_test();
  end
endmodule

bind apv_axis apv_axis_sva u_apv_axis_sva (.clk_sys(clk_sys), .rst(rst), .bus(bus),
  .rdata(rdata), .fbPulsePin(fbPulsePin), .fbRevPin(fbRevPin), .pins(pins));
